// File: rtl/tuf_regs.svh
`ifndef TUF_REGS_SVH
`define TUF_REGS_SVH
// =====================================================================
// Frame layout in bytes.
`define TUF_SOF_LEN 8'h04
`define TUF_FHDR_LEN 8'h18
`define TUF_NHDR_LEN 8'h10
`define TUF_SNAP_LEN 8'h08
`define TUF_IP_LEN 8'h14
`define TUF_UDP_LEN 8'h08
`define TUF_TDP_LEN 8'h08
`define TUF_CRC_LEN 8'h04
`define TUF_EOF_LEN 8'h04
// Total bytes from start delimiter through the packet header.
`define TUF_PRE_LEN 8'h58
// Record size alignment in bytes.
`define TUF_ALIGN 16'h0010
// Delimiter words, arbitrary neutral codes.
`define TUF_SOF_WORD 32'hbcb5_5656
`define TUF_EOF_WORD 32'hbc95_7575
// Default packet data length in bytes.
`define TUF_SEG_LEN 16'h0400
`define TUF_CRC_INIT 32'hffff_ffff
`endif

// File: rtl/tuf_pkg.sv
package tuf_pkg;
  // =====================================================================
  // Framer sequencer states.
  typedef enum logic [2:0] {
    TUF_IDLE = 3'b000,
    TUF_HDR = 3'b001,
    TUF_DATA = 3'b010,
    TUF_CRC = 3'b011,
    TUF_EOF = 3'b100
  } tuf_state_type;
endpackage : tuf_pkg

// File: rtl/tuf_fifo.sv
`timescale 1ns/1ps
// =====================================================================
// Synchronous FIFO with valid/ready on both sides.
module tuf_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic reset,
  // Fill side.
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // Drain side.
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH]; // Storage array.
  logic [AW-1:0] wr_q; // Write pointer.
  logic [AW-1:0] rd_q; // Read pointer.
  logic [AW:0] cnt_q; // Fill level.
  logic ready_q; // Registered not-full flag.
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  wire [AW:0] cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop); // Next fill level.
  // Ready comes from a flop fed by the next level, so the fill side sees no
  // combinational path; at the full mark a pop frees the slot for a push only in the next cycle.
  assign in_ready = ready_q;
  assign out_valid = cnt_q != '0;
  assign out_data = mem_q[rd_q];
  // Pointers and level; full and empty come from the level count.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      ready_q <= 1'b1;
    end else begin
      if (push) begin
        mem_q[wr_q] <= in_data;
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_d;
      ready_q <= cnt_d < (AW+1)'(DEPTH);
    end
  end
  // Level never exceeds the depth.
  fifo_level_a: assert property (@(posedge clk_sys) disable iff (reset) cnt_q <= (AW+1)'(DEPTH))
    else $error("fifo overfilled");
endmodule : tuf_fifo

// File: rtl/tuf_framer.sv
`timescale 1ns/1ps
`include "tuf_regs.svh"
// =====================================================================
// Contract
// - UDP/IP packet inside frame data field.
// - Delimiter, frame, network, SNAP, IP, UDP headers.
// - First field numbers packets, starting zero.
// - Second field holds record identifier.
// - Third field holds full record size.
// - Fourth field holds byte offset from zero.
// - Contiguous record segment follows the header.
// - Record sent as one or more packets.
// - Connectionless UDP transport over the link.
// - Each wavefront frame starts queued transfer.
// - Records padded to multiples of sixteen bytes.
module tuf_framer #(
  parameter int DEPTH = 16,
  parameter logic [15:0] SEG_LEN = `TUF_SEG_LEN
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic reset,
  // Frame tick and queued record descriptor.
  input wire logic frame_tick,
  input wire logic rec_pending,
  input wire logic [15:0] rec_id,
  input wire logic [15:0] rec_len,
  // Record words from local memory, 32 bits each, big endian.
  input wire logic [31:0] mem_data,
  input wire logic mem_valid,
  output logic mem_ready,
  // Link word stream towards the transmitter.
  output logic [31:0] link_data,
  output logic link_valid,
  output logic link_sof,
  output logic link_eof,
  input wire logic link_ready,
  // Status.
  output logic rec_done,
  output logic busy
);
  import tuf_pkg::*;
  // =====================================================================
  // Input buffering.
  logic [31:0] fifo_data;
  logic fifo_valid;
  logic fifo_pop;
  tuf_fifo #(.WIDTH(32), .DEPTH(DEPTH)) tuf_fifo_i (
    .clk_sys(clk_sys),
    .reset(reset),
    .in_data(mem_data),
    .in_valid(mem_valid),
    .in_ready(mem_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop)
  );
  // =====================================================================
  // Sequencer state.
  tuf_state_type st_q, st_d;
  logic [7:0] widx_q; // Word index inside header.
  logic [15:0] seq_q; // Packet number within the record.
  logic [15:0] off_q; // Byte offset of this packet.
  logic [15:0] size_q; // Padded record size.
  logic [15:0] id_q; // Record identifier.
  logic [15:0] seg_q; // Bytes carried by this packet.
  logic [15:0] sent_q; // Bytes sent in this packet.
  logic [31:0] crc_q; // Running frame check.
  logic armed_q; // Frame tick seen, transfer allowed.
  logic [31:0] out_q;
  logic out_v_q, sof_q, eof_q, done_q;
  logic busy_q; // Busy flag, registered from the next state so it matches the state register.
  // Pad a length up to the next sixteen-byte boundary.
  function automatic logic [15:0] pad16(input logic [15:0] n);
    pad16 = (n + `TUF_ALIGN - 16'h0001) & ~(`TUF_ALIGN - 16'h0001);
  endfunction : pad16
  // Bitwise CRC-32 update over one word.
  function automatic logic [31:0] crc_upd(input logic [31:0] c, input logic [31:0] w);
    logic [31:0] r;
    r = c;
    for (int i = 31; i >= 0; i--) begin
      r = (r[31] ^ w[i]) ? ((r << 1) ^ 32'h04c1_1db7) : (r << 1);
    end
    crc_upd = r;
  endfunction : crc_upd
  // =====================================================================
  // Header word selection, 22 words from start delimiter to packet header.
  wire [15:0] left = size_q - off_q;
  wire [15:0] seg_n = (left > SEG_LEN) ? SEG_LEN : left;
  wire [15:0] udp_len = seg_n + 16'(`TUF_UDP_LEN) + 16'(`TUF_TDP_LEN);
  wire [15:0] ip_len = udp_len + 16'(`TUF_IP_LEN);
  logic [31:0] hdr_w;
  // Unlisted fields are zero here; addressing is filled by the link layer.
  always_comb begin
    case (widx_q)
      8'h00: hdr_w = `TUF_SOF_WORD;
      8'h0b: hdr_w = 32'haaaa_0300; // SNAP header start
      8'h0c: hdr_w = 32'h0000_0800; // SNAP carries IP
      8'h0d: hdr_w = {16'h4500, ip_len}; // IP version and length
      8'h0f: hdr_w = 32'h4011_0000; // Protocol UDP
      8'h13: hdr_w = {udp_len, 16'h0000}; // UDP length
      8'h14: hdr_w = {seq_q, id_q};
      8'h15: hdr_w = {size_q, off_q};
      default: hdr_w = 32'h0000_0000;
    endcase
  end
  wire hdr_last = widx_q == 8'h15;
  wire data_last = sent_q + 16'h0004 >= seg_q;
  wire take = !out_v_q || link_ready;
  assign fifo_pop = (st_q == TUF_DATA) && take && fifo_valid;
  // Next state selection.
  always_comb begin
    st_d = st_q;
    case (st_q)
      TUF_IDLE: st_d = (armed_q && rec_pending) ? TUF_HDR : TUF_IDLE;
      TUF_HDR: st_d = (take && hdr_last) ? TUF_DATA : TUF_HDR;
      TUF_DATA: st_d = (fifo_pop && data_last) ? TUF_CRC : TUF_DATA;
      TUF_CRC: st_d = take ? TUF_EOF : TUF_CRC;
      TUF_EOF: st_d = take ? TUF_IDLE : TUF_EOF;
      default: st_d = TUF_IDLE;
    endcase
  end
  // =====================================================================
  // Main sequencer; each packet is one frame.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st_q <= TUF_IDLE;
      widx_q <= 8'h00;
      seq_q <= 16'h0000;
      off_q <= 16'h0000;
      size_q <= 16'h0000;
      id_q <= 16'h0000;
      seg_q <= 16'h0000;
      sent_q <= 16'h0000;
      crc_q <= `TUF_CRC_INIT;
      armed_q <= 1'b0;
      out_q <= 32'h0000_0000;
      out_v_q <= 1'b0;
      sof_q <= 1'b0;
      eof_q <= 1'b0;
      done_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      st_q <= st_d;
      busy_q <= st_d != TUF_IDLE;
      done_q <= 1'b0;
      if (take) begin
        out_v_q <= 1'b0;
        sof_q <= 1'b0;
        eof_q <= 1'b0;
      end
      if (frame_tick) begin
        armed_q <= 1'b1;
      end
      case (st_q)
        TUF_IDLE: begin
          widx_q <= 8'h00;
          crc_q <= `TUF_CRC_INIT;
          if (armed_q && rec_pending) begin
            if (off_q == 16'h0000) begin
              size_q <= pad16(rec_len);
              id_q <= rec_id;
            end
          end
        end
        TUF_HDR: if (take) begin
          out_q <= hdr_w;
          out_v_q <= 1'b1;
          sof_q <= widx_q == 8'h00;
          widx_q <= widx_q + 8'h01;
          seg_q <= seg_n;
          sent_q <= 16'h0000;
          if (widx_q != 8'h00) begin
            crc_q <= crc_upd(crc_q, hdr_w);
          end
        end
        TUF_DATA: if (fifo_pop) begin
          out_q <= fifo_data;
          out_v_q <= 1'b1;
          sent_q <= sent_q + 16'h0004;
          crc_q <= crc_upd(crc_q, fifo_data);
        end
        TUF_CRC: if (take) begin
          out_q <= ~crc_q;
          out_v_q <= 1'b1;
        end
        TUF_EOF: if (take) begin
          out_q <= `TUF_EOF_WORD;
          out_v_q <= 1'b1;
          eof_q <= 1'b1;
          if (off_q + seg_q >= size_q) begin
            seq_q <= 16'h0000;
            off_q <= 16'h0000;
            done_q <= 1'b1;
            armed_q <= frame_tick;
          end else begin
            seq_q <= seq_q + 16'h0001;
            off_q <= off_q + seg_q;
          end
        end
        default: ;
      endcase
    end
  end
  assign link_data = out_q;
  assign link_valid = out_v_q;
  assign link_sof = sof_q;
  assign link_eof = eof_q;
  assign rec_done = done_q;
  assign busy = busy_q;
  // =====================================================================
  // Checks.
  first_seq_zero_a: assert property (@(posedge clk_sys) disable iff (reset)
    $rose(busy) && off_q == 16'h0000 |-> seq_q == 16'h0000) else $error("first packet not zero");
  size_aligned_a: assert property (@(posedge clk_sys) disable iff (reset)
    st_q == TUF_DATA |-> size_q[3:0] == 4'h0) else $error("record size not aligned");
  seq_step_a: assert property (@(posedge clk_sys) disable iff (reset)
    st_q == TUF_EOF && take && off_q + seg_q < size_q |=> seq_q == $past(seq_q) + 16'h0001)
    else $error("sequence not incremented");
  off_step_a: assert property (@(posedge clk_sys) disable iff (reset)
    st_q == TUF_EOF && take && off_q + seg_q < size_q |=> off_q == $past(off_q) + $past(seg_q))
    else $error("offset step wrong");
  size_stable_a: assert property (@(posedge clk_sys) disable iff (reset)
    st_q != TUF_IDLE |=> $stable(size_q)) else $error("record size changed");
  sof_first_a: assert property (@(posedge clk_sys) disable iff (reset)
    link_sof && link_valid |-> link_data == `TUF_SOF_WORD) else $error("bad start word");
  eof_last_a: assert property (@(posedge clk_sys) disable iff (reset)
    st_q == TUF_EOF && take |=> link_eof && link_data == `TUF_EOF_WORD) else $error("bad end word");
  hold_out_a: assert property (@(posedge clk_sys) disable iff (reset)
    link_valid && !link_ready |=> link_valid && $stable(link_data)) else $error("word dropped");
  start_armed_a: assert property (@(posedge clk_sys) disable iff (reset)
    st_q == TUF_IDLE && st_d == TUF_HDR |-> armed_q) else $error("started without frame");
endmodule : tuf_framer

// File: sim/tuf_link_sink.sv
`timescale 1ns/1ps
// =====================================================================
// Far-side link receiver model that takes every offered frame word.
module tuf_link_sink (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic reset,
  // Link word stream from the framer.
  input wire logic [31:0] link_data,
  input wire logic link_valid,
  input wire logic link_sof,
  input wire logic link_eof,
  output logic link_ready,
  // Test control: toggle ready every cycle to model a slow receiver.
  input wire logic stall
);
  // Captured words as {sof, eof, data}, read by the bench.
  logic [33:0] got[$];

  // Accept on the edge where valid and ready meet, then pick the next ready.
  always @(posedge clk_sys) begin
    if (reset) begin
      link_ready <= 1'b0;
    end else begin
      if (link_valid && link_ready) begin
        got.push_back({link_sof, link_eof, link_data});
      end
      link_ready <= stall ? ~link_ready : 1'b1;
    end
  end
endmodule : tuf_link_sink

// File: sim/tuf_framer_tb.sv
`timescale 1ns/1ps
`include "tuf_regs.svh"
// =====================================================================
// Self-checking bench for the telemetry framer.
module tuf_framer_tb;
  // Short packets keep frames small; every expectation uses this value.
  localparam logic [15:0] SEG = 16'h0010;
  logic clk_sys, reset, frame_tick, rec_pending, mem_ready, stall;
  logic [15:0] rec_id, rec_len;
  logic [31:0] link_data;
  logic link_valid, link_sof, link_eof, link_ready, rec_done, busy;
  logic [31:0] mem_base; // Pattern base of the current record.
  int mem_idx, mem_cnt, mismatches, total_checks, p;
  wire logic [31:0] mem_data = mem_base + 32'(mem_idx);
  wire logic mem_valid = (mem_idx < mem_cnt);

  tuf_framer #(.DEPTH(16), .SEG_LEN(SEG)) tuf_framer_i (.clk_sys(clk_sys), .reset(reset),
    .frame_tick(frame_tick), .rec_pending(rec_pending), .rec_id(rec_id), .rec_len(rec_len),
    .mem_data(mem_data), .mem_valid(mem_valid), .mem_ready(mem_ready), .link_data(link_data),
    .link_valid(link_valid), .link_sof(link_sof), .link_eof(link_eof), .link_ready(link_ready),
    .rec_done(rec_done), .busy(busy));
  tuf_link_sink tuf_link_sink_i (.clk_sys(clk_sys), .reset(reset), .link_data(link_data),
    .link_valid(link_valid), .link_sof(link_sof), .link_eof(link_eof), .link_ready(link_ready),
    .stall(stall));

  // 100 ns clock.
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // Memory source: a word leaves when the framer takes it.
  always @(posedge clk_sys) begin
    if (mem_valid && mem_ready) begin
      mem_idx <= mem_idx + 1;
    end
  end

  task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] seen);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check_word

  task automatic check_bit(input string what, input logic exp, input logic seen);
    check_word(what, {31'h0, exp}, {31'h0, seen});
  endtask : check_bit

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : report_and_stop

  // Reference frame check over captured words first..last: MSB-first CRC-32, preset to all ones, inverted.
  function automatic logic [31:0] crc_ref(input int first, input int last);
    logic [31:0] c;
    logic [31:0] w;
    c = `TUF_CRC_INIT;
    for (int j = first; j <= last; j++) begin
      w = tuf_link_sink_i.got[j][31:0];
      for (int i = 31; i >= 0; i--) begin
        c = (c[31] ^ w[i]) ? ((c << 1) ^ 32'h04c1_1db7) : (c << 1);
      end
    end
    crc_ref = ~c;
  endfunction : crc_ref

  // Walks one captured frame at index p and moves p past it.
  task automatic check_frame(input logic [15:0] seq, id, size, off);
    int nw;
    logic [15:0] udp;
    nw = int'(SEG) / 4;
    udp = SEG + 16'(`TUF_UDP_LEN) + 16'(`TUF_TDP_LEN);
    check_word("sof word", `TUF_SOF_WORD, tuf_link_sink_i.got[p][31:0]);
    check_bit("sof flag", 1'b1, tuf_link_sink_i.got[p][33]);
    check_word("ip length", {16'h4500, udp + 16'(`TUF_IP_LEN)}, tuf_link_sink_i.got[p+13][31:0]);
    check_word("udp length", {udp, 16'h0000}, tuf_link_sink_i.got[p+19][31:0]);
    check_word("seq id", {seq, id}, tuf_link_sink_i.got[p+20][31:0]);
    check_word("size off", {size, off}, tuf_link_sink_i.got[p+21][31:0]);
    for (int k = 0; k < nw; k++) begin
      check_word("data", mem_base + 32'(off / 4) + 32'(k), tuf_link_sink_i.got[p+22+k][31:0]);
    end
    check_word("crc word", crc_ref(p + 1, p + 21 + nw), tuf_link_sink_i.got[p+22+nw][31:0]);
    check_word("eof word", `TUF_EOF_WORD, tuf_link_sink_i.got[p+23+nw][31:0]);
    check_bit("eof flag", 1'b1, tuf_link_sink_i.got[p+23+nw][32]);
    p = p + 24 + nw;
  endtask : check_frame

  // Queues one record, arms it with a tick and waits for completion.
  // Memory holds the record already padded with filler words to the alignment.
  task automatic run_record(input logic [15:0] id, len, input logic [31:0] base, input logic slow);
    int n;
    int sz;
    sz = ((int'(len) + int'(`TUF_ALIGN) - 1) / int'(`TUF_ALIGN)) * int'(`TUF_ALIGN);
    @(posedge clk_sys);
    stall <= slow;
    mem_base <= base;
    mem_idx <= 0;
    mem_cnt <= sz / 4;
    rec_id <= id;
    rec_len <= len;
    rec_pending <= 1'b1;
    frame_tick <= 1'b1;
    @(posedge clk_sys);
    frame_tick <= 1'b0;
    n = 0;
    @(posedge clk_sys);
    @(negedge clk_sys);
    check_bit("busy", 1'b1, busy);
    while (rec_done !== 1'b1 && n < 3000) begin
      @(negedge clk_sys);
      n++;
    end
    check_bit("rec_done", 1'b1, rec_done);
    @(posedge clk_sys);
    rec_pending <= 1'b0;
    // The end word may still wait on a stalled receiver; let it be taken first.
    repeat (3) @(negedge clk_sys);
    for (int s = 0; s < sz / int'(SEG); s++) begin
      check_frame(16'(s), id, 16'(sz), 16'(s) * SEG);
    end
    check_word("word count", 32'(p), 32'(tuf_link_sink_i.got.size()));
  endtask : run_record

  // A pending record without a frame tick must not start.
  task automatic no_tick_test;
    @(posedge clk_sys);
    rec_id <= 16'h0077;
    rec_len <= 16'h0010;
    rec_pending <= 1'b1;
    repeat (20) @(posedge clk_sys);
    @(negedge clk_sys);
    check_bit("busy idle", 1'b0, busy);
    check_word("no words", 32'h0, 32'(tuf_link_sink_i.got.size()));
    @(posedge clk_sys);
    rec_pending <= 1'b0;
  endtask : no_tick_test

  // Watchdog sized well above the four scenarios.
  initial begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    report_and_stop;
  end

  initial begin
    reset = 1'b1;
    frame_tick = 1'b0;
    rec_pending = 1'b0;
    rec_id = 16'h0;
    rec_len = 16'h0;
    stall = 1'b0;
    mem_base = 32'h0;
    mem_idx = 0;
    mem_cnt = 0;
    mismatches = 0;
    total_checks = 0;
    p = 0;
    repeat (4) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    no_tick_test();
    run_record(16'h00a5, 16'h0010, 32'hd000_0000, 1'b0);
    run_record(16'h0123, 16'h0030, 32'he100_0000, 1'b1);
    run_record(16'h0456, 16'h0014, 32'hf200_0000, 1'b1);
    report_and_stop;
  end
endmodule : tuf_framer_tb
